/* File: sfc_core.sv */
// Serial flash command interpreter: register commands, busy indication,
// plain and fast reads, page erase. Pins arrive asynchronous to i_clk and
// are synchronised; serial clock must stay below i_clk / 8.
`timescale 1ns/100ps
`include "sfc_defines.svh"
module sfc_core #(
  parameter int unsigned AW    = 20,
  parameter int unsigned WRITE_NS = `SFC_WRITE_NS
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Serial pins from the host
  input  wire logic i_cs_n,
  input  wire logic i_sclk,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  // Serial output pin
  output logic      o_so,
  output logic      o_so_oe
);

  // Register write time in clock cycles, rounded up
  localparam int unsigned WR_CYC  = (WRITE_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS;
  localparam logic [23:0] WR_LOAD = 24'(WR_CYC - 1);

  // Pin synchronisers and delayed copies for edge detection
  logic cs_m_r, cs_s_r, cs_d_r;
  logic sck_m_r, sck_s_r, sck_d_r;
  logic si_m_r, si_s_r;
  logic wp_m_r, wp_s_r;
  // Sequencer
  sfc_pkg::sfc_state_e st_r, st_nxt;
  logic [4:0]    cnt_r;     // Bits in current phase
  logic [4:0]    dcnt_r;    // Data bits of a register write
  logic [23:0]   in_r;      // Serial input shifter
  logic [7:0]    cmd_r;     // Opcode of this frame
  logic [AW-1:0] addr_r;    // Array read address
  // Registers
  logic [15:0]   stat_r;    // Status register
  logic          dpage_r;   // Double page flag
  logic [23:0]   wr_cnt_r;  // Write cycle timer
  // Page erase walker
  logic [AW-1:0] er_addr_r;
  logic [9:0]    er_left_r;
  // Read data buffer, two entries
  logic [7:0]    f_mem_r [0:1];
  logic          f_wp_r, f_rp_r;
  logic [1:0]    f_cnt_r;
  logic          rd_pend_r; // Array read in flight
  logic [7:0]    mem_rdata;
  // Output shifter
  logic [7:0]    osh_r;
  logic [2:0]    bcnt_r;

  // Page arithmetic: next load address inside a page, and page start
  function automatic logic [AW-1:0] page_next(input logic [AW-1:0] a,
                                              input logic big);
    logic [8:0] lo9;
    logic [7:0] lo8;
    lo9 = a[8:0] + 9'h001;
    lo8 = a[7:0] + 8'h01;
    page_next = big ? {a[AW-1:9], lo9} : {a[AW-1:8], lo8};
  endfunction : page_next

  function automatic logic [AW-1:0] page_base(input logic [AW-1:0] a,
                                              input logic big);
    page_base = big ? {a[AW-1:9], 9'h000} : {a[AW-1:8], 8'h00};
  endfunction : page_base

  // Edge and frame events from synchronised pins
  wire cs_fall_w = ~cs_s_r & cs_d_r;
  wire cs_rise_w = cs_s_r & ~cs_d_r;
  wire sck_rise  = ~cs_s_r & sck_s_r & ~sck_d_r;
  wire sck_fall  = ~cs_s_r & ~sck_s_r & sck_d_r;
  wire [23:0] in_w = {in_r[22:0], si_s_r};
  wire [7:0]  opc_w = in_w[7:0];
  wire busy_w = stat_r[`SFC_ST_BUSY];
  wire latch_w = stat_r[`SFC_ST_LATCH];
  wire is_rd_reg_w = (opc_w == `SFC_OP_RD_CFG) || (opc_w == `SFC_OP_RD_STAT_LO)
                  || (opc_w == `SFC_OP_RD_STAT_HI);
  wire is_wr_reg_w = (opc_w == `SFC_OP_WR_STATUS) || (opc_w == `SFC_OP_WR_CFG);

  // Hardware protection and lock-down of the status register
  wire locked_w = stat_r[`SFC_ST_PROT_HI] | (stat_r[`SFC_ST_PROT_LO] & ~wp_s_r);

  // Opcode decode: rejected commands go to the ignore state
  wire sfc_pkg::sfc_state_e dec_st_w =
    is_rd_reg_w                          ? sfc_pkg::ST_RREG :
    (opc_w == `SFC_OP_BUSY_IND)          ? sfc_pkg::ST_BUSY :
    (opc_w == `SFC_OP_READ)              ? sfc_pkg::ST_ADDR :
    (opc_w == `SFC_OP_FAST_READ && !busy_w) ? sfc_pkg::ST_ADDR :
    (is_wr_reg_w && latch_w && !busy_w)  ? sfc_pkg::ST_WDATA :
    (opc_w == `SFC_OP_PG_ERASE && latch_w && !busy_w) ? sfc_pkg::ST_ADDR :
    (opc_w == `SFC_OP_SET_LATCH && !busy_w) ? sfc_pkg::ST_WARM :
    sfc_pkg::ST_IGNORE;

  // Where the address phase leads
  wire sfc_pkg::sfc_state_e addr_st_w =
    (cmd_r == `SFC_OP_READ)      ? sfc_pkg::ST_RDATA :
    (cmd_r == `SFC_OP_FAST_READ) ? sfc_pkg::ST_DUMMY :
    sfc_pkg::ST_EARM;

  // Commit events on deselect
  wire wr_len_ok_w = (dcnt_r == `SFC_WR_SHORT) || (dcnt_r == `SFC_WR_LONG);
  wire in_wdata_w  = cs_rise_w && (st_r == sfc_pkg::ST_WDATA);
  wire commit_stat = in_wdata_w && (cmd_r == `SFC_OP_WR_STATUS)
                  && wr_len_ok_w && !locked_w;
  wire commit_cfg  = in_wdata_w && (cmd_r == `SFC_OP_WR_CFG)
                  && (dcnt_r == `SFC_WR_SHORT);
  wire commit_wel  = cs_rise_w && (st_r == sfc_pkg::ST_WARM);
  wire commit_er   = cs_rise_w && (st_r == sfc_pkg::ST_EARM);
  wire start_w     = commit_stat | commit_cfg | commit_er;

  // New status value: short write clears bits 14, 9, 8; 16-bit write
  // sends bits 7..0 first; bits 15, 10, 1, 0 never written
  wire [7:0]  st_lo_w = (dcnt_r == `SFC_WR_SHORT) ? in_r[7:0] : in_r[15:8];
  wire [7:0]  st_hi_w = (dcnt_r == `SFC_WR_SHORT) ? 8'h00 : in_r[7:0];
  wire [2:0]  lb_w    = stat_r[13:11] | st_hi_w[5:3];
  wire [15:0] stat_new_w = {stat_r[15], st_hi_w[6], lb_w, stat_r[10],
                            st_hi_w[1:0], st_lo_w[7:2], stat_r[1:0]};

  // Read buffer handshake; fetching stalls while both entries are full
  wire       f_in_rdy_w  = (f_cnt_r != 2'h2);
  wire       f_out_vld_w = (f_cnt_r != 2'h0);
  wire [7:0] f_dout_w    = f_mem_r[f_rp_r];
  wire fetch_on_w = (st_r == sfc_pkg::ST_RDATA) || (st_r == sfc_pkg::ST_DUMMY);
  wire fetch_w    = fetch_on_w && !rd_pend_r && f_in_rdy_w;
  wire out_st_w   = (st_r == sfc_pkg::ST_RDATA) || (st_r == sfc_pkg::ST_RREG);
  wire pop_w      = sck_fall && (st_r == sfc_pkg::ST_RDATA) && (bcnt_r == 3'h0)
                  && f_out_vld_w;
  wire [7:0] reg_byte_w = (cmd_r == `SFC_OP_RD_CFG)    ? {dpage_r, 7'h00} :
                          (cmd_r == `SFC_OP_RD_STAT_HI) ? stat_r[15:8] : stat_r[7:0];
  wire [7:0] byte_w = (st_r == sfc_pkg::ST_RDATA) ? f_dout_w : reg_byte_w;
  wire out_on_w = ~cs_s_r && (out_st_w || st_r == sfc_pkg::ST_BUSY);

  // Two-flop synchronisers plus delayed copies
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {cs_m_r, cs_s_r, cs_d_r}    <= 3'h7;
      {sck_m_r, sck_s_r, sck_d_r} <= 3'h0;
      {si_m_r, si_s_r, wp_m_r, wp_s_r} <= 4'h0;
    end
    else
    begin
      {cs_m_r, cs_s_r, cs_d_r}    <= {i_cs_n, cs_m_r, cs_s_r};
      {sck_m_r, sck_s_r, sck_d_r} <= {i_sclk, sck_m_r, sck_s_r};
      {si_m_r, si_s_r, wp_m_r, wp_s_r} <= {i_si, si_m_r, i_wp_n, wp_m_r};
    end
  end

  // Next state; deselect always returns to idle
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      sfc_pkg::ST_OPC:   if (sck_rise && cnt_r == `SFC_BYTE_LAST) st_nxt = dec_st_w;
      sfc_pkg::ST_ADDR:  if (sck_rise && cnt_r == `SFC_ADDR_LAST) st_nxt = addr_st_w;
      sfc_pkg::ST_DUMMY: if (sck_rise && cnt_r == `SFC_BYTE_LAST) st_nxt = sfc_pkg::ST_RDATA;
      sfc_pkg::ST_WARM,
      sfc_pkg::ST_EARM:  if (sck_rise) st_nxt = sfc_pkg::ST_IGNORE;
      sfc_pkg::ST_IDLE, sfc_pkg::ST_RDATA, sfc_pkg::ST_RREG, sfc_pkg::ST_BUSY,
      sfc_pkg::ST_WDATA, sfc_pkg::ST_IGNORE: st_nxt = st_r;
      default:           st_nxt = sfc_pkg::ST_IDLE;
    endcase
    if (cs_s_r)
      st_nxt = sfc_pkg::ST_IDLE;
    else if (cs_fall_w)
      st_nxt = sfc_pkg::ST_OPC;
  end

  // State and input shifting on serial clock rise, msb first
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      st_r   <= sfc_pkg::ST_IDLE;
      {cnt_r, dcnt_r} <= 10'h000;
      in_r   <= 24'h000000;
      cmd_r  <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      if (cs_fall_w)
        {cnt_r, dcnt_r} <= 10'h000;
      else if (sck_rise)
      begin
        in_r  <= in_w;
        cnt_r <= (st_nxt != st_r) ? 5'h00 : cnt_r + 5'h01;
        if (st_r == sfc_pkg::ST_WDATA && dcnt_r != `SFC_WR_SAT)
          dcnt_r <= dcnt_r + 5'h01;
        if (st_r == sfc_pkg::ST_OPC && cnt_r == `SFC_BYTE_LAST)
          cmd_r <= opc_w;
      end
    end
  end

  // Read address: capture, then increment per fetched byte, wrapping
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      addr_r <= '0;
    else if (sck_rise && st_r == sfc_pkg::ST_ADDR && cnt_r == `SFC_ADDR_LAST)
      addr_r <= in_w[AW-1:0];
    else if (fetch_w)
      addr_r <= addr_r + 1'b1;
  end

  // Status, page config, write latch and write cycle timer
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stat_r   <= `SFC_STAT_RST;
      dpage_r  <= `SFC_CFG_RST;
      wr_cnt_r <= 24'h000000;
    end
    else
    begin
      if (commit_wel)
        stat_r[`SFC_ST_LATCH] <= 1'b1;
      if (commit_stat)
        stat_r[15:2] <= stat_new_w[15:2];
      if (commit_cfg)
        dpage_r <= in_r[`SFC_CFG_DPAGE];
      if (start_w)
      begin
        stat_r[`SFC_ST_BUSY] <= 1'b1;
        wr_cnt_r <= WR_LOAD;
      end
      else if (busy_w && wr_cnt_r == 24'h000000)
        stat_r[1:0] <= 2'h0;
      else if (busy_w)
        wr_cnt_r <= wr_cnt_r - 24'h000001;
    end
  end

  // Page erase: fill the page with ones, wrapping inside it
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      er_addr_r <= '0;
      er_left_r <= 10'h000;
    end
    else if (commit_er)
    begin
      er_addr_r <= page_base(addr_r, dpage_r);
      er_left_r <= dpage_r ? `SFC_PAGE_LARGE : `SFC_PAGE_SMALL;
    end
    else if (er_left_r != 10'h000)
    begin
      er_addr_r <= page_next(er_addr_r, dpage_r);
      er_left_r <= er_left_r - 10'h001;
    end
  end

  // Read buffer: array reads fill it, the output shifter drains it
  always_ff @(posedge i_clk)
  begin
    if (i_rst || cs_fall_w)
    begin
      {f_wp_r, f_rp_r, rd_pend_r} <= 3'h0;
      f_cnt_r <= 2'h0;
    end
    else
    begin
      rd_pend_r <= fetch_w;
      if (rd_pend_r)
      begin
        f_mem_r[f_wp_r] <= mem_rdata;
        f_wp_r <= ~f_wp_r;
      end
      if (pop_w)
        f_rp_r <= ~f_rp_r;
      f_cnt_r <= f_cnt_r + {1'b0, rd_pend_r} - {1'b0, pop_w};
    end
  end

  // Serial output, changed on falling serial clock or live busy flag
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      {o_so, o_so_oe} <= 2'h0;
      osh_r  <= 8'h00;
      bcnt_r <= 3'h0;
    end
    else
    begin
      o_so_oe <= out_on_w;
      if (cs_fall_w)
        bcnt_r <= 3'h0;
      if (st_r == sfc_pkg::ST_BUSY)
        o_so <= busy_w;
      else if (sck_fall && out_st_w)
      begin
        o_so   <= (bcnt_r == 3'h0) ? byte_w[7] : osh_r[7];
        osh_r  <= (bcnt_r == 3'h0) ? {byte_w[6:0], 1'b0} : {osh_r[6:0], 1'b0};
        bcnt_r <= bcnt_r + 3'h1;
      end
    end
  end

  // Flash array
  sfc_mem #(.AW(AW)) u_mem (
    .i_clk   (i_clk),
    .i_we    (er_left_r != 10'h000),
    .i_waddr (er_addr_r),
    .i_wdata (8'hFF),
    .i_raddr (addr_r),
    .o_rdata (mem_rdata)
  );

  // Checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_busy_ind_fall: assert property (st_r == sfc_pkg::ST_BUSY && $past(st_r) == sfc_pkg::ST_BUSY
    && $past(st_r, 2) == sfc_pkg::ST_BUSY |-> !$rose(o_so)) else $error("busy line rose");
  a_deselect_hiz: assert property (cs_rise_w |=> !o_so_oe)
    else $error("output still driven after deselect");
  a_latch_needed: assert property ($rose(busy_w) |-> $past(latch_w))
    else $error("write cycle without latch");
  a_fixed_bits: assert property ($rose(busy_w) |-> stat_r[15] == $past(stat_r[15])
    && stat_r[10] == $past(stat_r[10])) else $error("fixed status bit changed");
  a_bad_length: assert property (in_wdata_w && !wr_len_ok_w |=> !busy_w)
    else $error("bad length write started");
  a_short_clear: assert property (commit_stat && dcnt_r == `SFC_WR_SHORT
    |=> stat_r[14] == 1'b0 && stat_r[9:8] == 2'h0) else $error("short write kept bits");
  a_end_clears: assert property ($fell(busy_w) |-> !latch_w)
    else $error("latch survived write cycle");
  a_hw_lock: assert property (in_wdata_w && locked_w && cmd_r == `SFC_OP_WR_STATUS
    |=> !busy_w) else $error("locked status written");
  a_fast_reject: assert property (st_r == sfc_pkg::ST_OPC && sck_rise && cnt_r == `SFC_BYTE_LAST
    && opc_w == `SFC_OP_FAST_READ && busy_w |=> st_r == sfc_pkg::ST_IGNORE)
    else $error("fast read accepted while busy");
  a_erase_len: assert property (commit_er ##1 1'b1 |-> er_left_r
    == (dpage_r ? `SFC_PAGE_LARGE : `SFC_PAGE_SMALL)) else $error("erase length wrong");

  c_fast_data: cover property (st_r == sfc_pkg::ST_RDATA && cmd_r == `SFC_OP_FAST_READ && pop_w);
  c_busy_ind:  cover property (st_r == sfc_pkg::ST_BUSY && $fell(o_so));
  c_stat_long: cover property (commit_stat && dcnt_r == `SFC_WR_LONG);
  c_erase:     cover property (commit_er && dpage_r);

endmodule : sfc_core

/* File: sfc_defines.svh */
// Constants of the serial flash command block: opcodes, bit positions,
// reset values and timing. Included by sfc_core and by the bench, not by sfc_mem.
`ifndef SFC_DEFINES_SVH
`define SFC_DEFINES_SVH

// Opcodes taken from the serial input, msb first
`define SFC_OP_WR_STATUS  8'h01
`define SFC_OP_READ       8'h03
`define SFC_OP_RD_STAT_LO 8'h05
`define SFC_OP_SET_LATCH  8'h06
`define SFC_OP_FAST_READ  8'h0B
`define SFC_OP_RD_CFG     8'h15
`define SFC_OP_BUSY_IND   8'h25
`define SFC_OP_WR_CFG     8'h31
`define SFC_OP_RD_STAT_HI 8'h35
`define SFC_OP_PG_ERASE   8'h81

// Status register bit positions
`define SFC_ST_BUSY       0
`define SFC_ST_LATCH      1
`define SFC_ST_PROT_LO    7
`define SFC_ST_PROT_HI    8
`define SFC_ST_QUAD       9
`define SFC_ST_PCOMP      14

// Page config bit position and reset values
`define SFC_CFG_DPAGE     7
`define SFC_CFG_RST       1'h0
`define SFC_STAT_RST      16'h0000

// Phase lengths in serial clocks, and page sizes in bytes
`define SFC_ADDR_LAST     5'h17
`define SFC_BYTE_LAST     5'h07
`define SFC_WR_SHORT      5'h08
`define SFC_WR_LONG       5'h10
`define SFC_WR_SAT        5'h11
`define SFC_PAGE_SMALL    10'h100
`define SFC_PAGE_LARGE    10'h200

// Timing: clock period and register write time, both in ns
`define SFC_CLK_NS        25
`define SFC_WRITE_NS      5000000

`endif

/* File: sfc_pkg.sv */
// Types of the serial flash command block.
// Used by sfc_core only, always written with the package scope.
package sfc_pkg;

  // Command sequencer states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_OPC    = 4'b0001,
    ST_ADDR   = 4'b0010,
    ST_DUMMY  = 4'b0011,
    ST_RDATA  = 4'b0100,
    ST_RREG   = 4'b0101,
    ST_BUSY   = 4'b0110,
    ST_WDATA  = 4'b0111,
    ST_WARM   = 4'b1000,
    ST_EARM   = 4'b1001,
    ST_IGNORE = 4'b1010
  } sfc_state_e;

endpackage : sfc_pkg

/* File: sfc_mem.sv */
// Byte-wide flash array model: one write port, one registered read port.
// Assumes a single clock; read data appear one edge after the address.
`timescale 1ns/100ps
module sfc_mem #(
  parameter int AW = 20
) (
  // Clock
  input  wire logic          i_clk,
  // Write port
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  // Read port
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);

  // Array storage
  logic [7:0] mem_r [0:(1<<AW)-1];

  // Write and registered read
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_r[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_r[i_raddr];
  end

endmodule : sfc_mem

/* File: sfc_host_model.sv */
// Host side of the serial link: chip select, serial clock and data in.
// Assumes mode 0 and at least HALF i_clk cycles per serial clock half period.
`timescale 1ns/100ps
module sfc_host_model #(
  parameter int HALF = 10  // I_clk cycles of serial clock high time; the low time is twice that
) (
  // Clock
  input  wire logic i_clk,
  // Serial pins
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  logic so_last;  // Last driven level of the output line
  logic so_w;     // Output line as the host sees it
  logic oe_seen;  // Device drove the line in this frame

  // A floating line shows the inverse of the last driven level
  assign so_w = i_so_oe ? i_so : ~so_last;

  // Remember the driven level
  always @(posedge i_clk)
    if (i_so_oe)
      so_last <= i_so;

  // Deselected, clock idles low
  initial
  begin
    o_cs_n  = 1'b1;
    o_sclk  = 1'b0;
    o_si    = 1'b0;
    so_last = 1'b0;
    oe_seen = 1'b0;
  end

  // Wait falling edges of i_clk
  task automatic idle(input int n);
    repeat (n) @(negedge i_clk);
  endtask : idle

  // Select the device
  task automatic sel();
    @(negedge i_clk);
    o_cs_n  = 1'b0;
    oe_seen = 1'b0;
    idle(HALF);
  endtask : sel

  // Deselect on a byte boundary, keep minimum high time
  task automatic desel();
    idle(HALF);
    o_cs_n = 1'b1;
    o_si   = ~o_si;
    idle(HALF);
  endtask : desel

  // One byte each way, sample before each rising edge
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
    begin
      q[i] = so_w;
      if (i_so_oe)
        oe_seen = 1'b1;
      o_si   = d[i];
      idle(HALF);
      o_sclk = 1'b1;
      idle(HALF);
      o_sclk = 1'b0;
      idle(HALF);
    end
  endtask : xfer

  // Opcode and n bytes from d, last byte seen is returned
  task automatic cmd(input logic [7:0] op, input int n, input logic [39:0] d, output logic [7:0] r);
    sel();
    xfer(op, r);
    for (int k = n - 1; k >= 0; k--)
      xfer(d[8*k +: 8], r);
    desel();
  endtask : cmd

  // Busy indication: count cycles until the line falls, then watch for a rise
  task automatic busy_watch(input int lim, output logic first, output logic rose, output int n);
    logic [7:0] q;
    sel();
    xfer(8'h25, q);
    first = so_w;
    rose  = 1'b0;
    n     = 0;
    while (so_w === 1'b1 && n < lim)
    begin
      idle(1);
      n++;
    end
    repeat (8)
    begin
      idle(1);
      if (so_w !== 1'b0)
        rose = 1'b1;
    end
    desel();
  endtask : busy_watch
endmodule : sfc_host_model

/* File: sfc_core_tb_top.sv */
// Self-checking bench of the serial flash command block.
// Assumes the host model in its own file; short write time for simulation.
`timescale 1ns/100ps
`include "sfc_defines.svh"
module sfc_core_tb_top;
  localparam int WRITE_NS = 100000;  // Write time of 4000 cycles, outlasts two reads
  localparam int LIM      = 6000;    // Bound on a busy wait, cycles

  logic       i_clk;        // System clock
  logic       i_rst;        // Synchronous reset
  logic       i_cs_n;       // Chip select, active low
  logic       i_sclk;       // Serial clock
  logic       i_si;         // Serial data in
  logic       i_wp_n;       // Write protect, active low
  logic       o_so;         // Serial data out
  logic       o_so_oe;      // Output enable
  logic [7:0] rd;           // Last byte read
  int         n_errors;     // Mismatches
  int         comparisons;  // Comparisons made

  // Device under test
  sfc_core #(.AW(12), .WRITE_NS(WRITE_NS)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n),
    .i_sclk(i_sclk), .i_si(i_si), .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe));

  // Host controller model
  sfc_host_model i_host (.i_clk(i_clk), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_si(i_si),
    .i_so(o_so), .i_so_oe(o_so_oe));

  // 40 MHz clock
  initial
    i_clk = 1'b0;
  always #12.5 i_clk = ~i_clk;

  // Byte comparison
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  // Bit comparison
  task automatic chk_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Counts and verdict, then end
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // Read a one-byte register and compare
  task automatic reg_is(input string what, input logic [7:0] op, input logic [7:0] exp);
    i_host.cmd(op, 1, 40'h0, rd);
    chk_byte(what, exp, rd);
  endtask : reg_is

  // Set the write enable latch
  task automatic set_write_latch_cmd();
    i_host.cmd(`SFC_OP_SET_LATCH, 0, 40'h0, rd);
  endtask : set_write_latch_cmd

  // Poll busy indication until the write ends
  task automatic wait_idle();
    logic f;
    logic r;
    int   n;
    i_host.busy_watch(LIM, f, r, n);
    chk_bit("busy seen", 1'b1, f);
    chk_bit("busy no rise", 1'b0, r);
    chk_bit("line released", 1'b0, o_so_oe);
    if (n >= LIM)
    begin
      n_errors++;
      $display("CHECK FAILED busy wait expected end seen timeout");
      stop_test();
    end
  endtask : wait_idle

  // Reset values of both registers
  task automatic t_reset();
    reg_is("cfg reset", `SFC_OP_RD_CFG, 8'h00);
    reg_is("stat lo reset", `SFC_OP_RD_STAT_LO, 8'h00);
    reg_is("stat hi reset", `SFC_OP_RD_STAT_HI, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // Config write: latch needed, exact length, timed busy
  task automatic t_cfg();
    i_host.cmd(`SFC_OP_WR_CFG, 1, 40'h80, rd);
    reg_is("cfg no latch", `SFC_OP_RD_CFG, 8'h00);
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_WR_CFG, 2, 40'h8080, rd);
    reg_is("cfg 16 bits", `SFC_OP_RD_CFG, 8'h00);
    reg_is("latch kept", `SFC_OP_RD_STAT_LO, 8'h02);
    i_host.cmd(`SFC_OP_WR_CFG, 1, 40'h80, rd);
    reg_is("busy in write", `SFC_OP_RD_STAT_LO, 8'h03);
    reg_is("cfg while busy", `SFC_OP_RD_CFG, 8'h80);
    wait_idle();
    reg_is("latch cleared", `SFC_OP_RD_STAT_LO, 8'h00);
    $display("test cfg done");
  endtask : t_cfg

  // Status write: latch, length, kept and cleared bits
  task automatic t_status();
    i_host.cmd(`SFC_OP_WR_STATUS, 1, 40'h7C, rd);
    reg_is("stat no latch", `SFC_OP_RD_STAT_LO, 8'h00);
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_WR_STATUS, 3, 40'h7CC600, rd);
    reg_is("stat 24 bits", `SFC_OP_RD_STAT_LO, 8'h02);
    i_host.cmd(`SFC_OP_WR_STATUS, 2, 40'h7FC6, rd);
    wait_idle();
    reg_is("stat lo 16", `SFC_OP_RD_STAT_LO, 8'h7C);
    reg_is("stat hi 16", `SFC_OP_RD_STAT_HI, 8'h42);
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_WR_STATUS, 1, 40'h04, rd);
    wait_idle();
    reg_is("stat lo 8", `SFC_OP_RD_STAT_LO, 8'h04);
    reg_is("stat hi 8", `SFC_OP_RD_STAT_HI, 8'h00);
    $display("test status done");
  endtask : t_status

  // Hardware protection locks the status register
  task automatic t_lock();
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_WR_STATUS, 1, 40'h80, rd);
    wait_idle();
    i_wp_n = 1'b0;
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_WR_STATUS, 1, 40'h00, rd);
    reg_is("locked", `SFC_OP_RD_STAT_LO, 8'h82);
    i_wp_n = 1'b1;
    i_host.cmd(`SFC_OP_WR_STATUS, 1, 40'h00, rd);
    wait_idle();
    reg_is("unlocked", `SFC_OP_RD_STAT_LO, 8'h00);
    $display("test lock done");
  endtask : t_lock

  // Erase with double page, plain and fast reads, wrap, read while busy
  task automatic t_reads();
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_PG_ERASE, 3, 40'h000100, rd);
    wait_idle();
    i_host.cmd(`SFC_OP_READ, 4, 40'h0001FF00, rd);
    chk_byte("double page end", 8'hFF, rd);
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_PG_ERASE, 3, 40'h000E00, rd);
    wait_idle();
    i_host.cmd(`SFC_OP_READ, 5, 40'h000FFF0000, rd);
    chk_byte("wrap to zero", 8'hFF, rd);
    i_host.cmd(`SFC_OP_FAST_READ, 5, 40'h0001FE0000, rd);
    chk_byte("fast read", 8'hFF, rd);
    set_write_latch_cmd();
    i_host.cmd(`SFC_OP_WR_CFG, 1, 40'h80, rd);
    i_host.cmd(`SFC_OP_FAST_READ, 5, 40'h0001FE0000, rd);
    chk_bit("fast refused", 1'b0, i_host.oe_seen);
    i_host.cmd(`SFC_OP_READ, 4, 40'h0001FE00, rd);
    chk_bit("read busy", 1'b1, i_host.oe_seen);
    chk_byte("read busy data", 8'hFF, rd);
    wait_idle();
    $display("test reads done");
  endtask : t_reads

  // Main sequence
  initial
  begin
    n_errors    = 0;
    comparisons = 0;
    i_rst       = 1'b1;
    i_wp_n      = 1'b1;
    repeat (4) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    t_reset();
    t_cfg();
    t_status();
    t_lock();
    t_reads();
    stop_test();
  end
endmodule : sfc_core_tb_top
